// ==== hdl/rsu_pkg.sv ====
package rsu_pkg;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam int CTRL_W = 39;
  localparam int RSV_HIGH_POS = 38;
  localparam int EARLY_POS = 37;
  localparam int OSC_POS = 36;
  localparam int WDEN_POS = 35;
  localparam int RSV_LOW_POS = 34;
  localparam int ADDR_MSB = 33;
  localparam int ADDR_LSB = 12;
  localparam int TMO_MSB = 11;
  localparam int TMO_LSB = 0;
  localparam int ADDR_W = 22;
  localparam int TMO_W = 12;

  localparam logic RSV_HIGH_VAL = 1'b1;
  localparam logic RSV_LOW_VAL = 1'b0;

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  localparam int BOOT_W = 24;
  localparam int WD_W = 29;
  localparam logic [16:0] WD_TAIL = 17'h00008;
  localparam logic [1:0] BOOT_TAIL = 2'h0;
  localparam logic [23:0] SERIAL_FACTORY_ADDR = 24'h000000;
  localparam logic [23:0] PARALLEL_FACTORY_ADDR = 24'h010000;

  // Reset image: every field clear, reserved bits at their fixed values.
  localparam logic [38:0] CTRL_RESET = 39'h4000000000;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int STAT_W = 32;
  localparam int STAT_STATE_LSB = 30;
  localparam int STAT_WDEN_POS = 29;
  localparam int CAUSE_W = 5;
  // Cause bits, higher index wins a tie.
  localparam int CAUSE_CFG_RESET = 4;
  localparam int CAUSE_CRC = 3;
  localparam int CAUSE_STATUS_PIN = 2;
  localparam int CAUSE_WATCHDOG = 1;
  localparam int CAUSE_CORE = 0;

  localparam logic [1:0] INFO_FACTORY = 2'h0;
  localparam logic [1:0] INFO_APP1 = 2'h1;
  localparam logic [1:0] INFO_APP2 = 2'h2;

  typedef enum logic [1:0] {
    RSU_FACTORY = 2'b01,
    RSU_APPLICATION = 2'b10
  } rsu_master_e;

endpackage

// ==== hdl/rsu_cause_rec.sv ====
`timescale 1ns/1ns
module rsu_cause_rec (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Trigger events, one bit each
  input wire logic [rsu_pkg::CAUSE_W-1:0] events,
  // Recorded cause
  output logic [rsu_pkg::CAUSE_W-1:0] cause
);
  import rsu_pkg::*;

  logic [CAUSE_W-1:0] next_cause;

  // Keep only the highest pending bit so the record stays one-hot.
  always_comb begin
    next_cause = '0;
    for (int i = 0; i < CAUSE_W; i++) begin
      if (events[i]) begin
        next_cause = '0;
        next_cause[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cause <= '0;
    end else if (|events) begin
      cause <= next_cause; // RQ11
    end
  end

endmodule

// ==== hdl/rsu_status_word.sv ====
`timescale 1ns/1ns
module rsu_status_word (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Current state
  input wire rsu_pkg::rsu_master_e state,
  input wire logic [rsu_pkg::CTRL_W-1:0] ctrl,
  input wire logic [1:0] info_sel,
  // Presented word
  output logic [rsu_pkg::STAT_W-1:0] word
);
  import rsu_pkg::*;

  function automatic logic [STAT_W-1:0] addr_word(
    input logic [1:0] st,
    input logic [CTRL_W-1:0] c
  );
    addr_word = {st, 6'h00, c[ADDR_MSB:ADDR_LSB], BOOT_TAIL};
  endfunction

  function automatic logic c_wden(input logic [CTRL_W-1:0] c);
    c_wden = c[WDEN_POS];
  endfunction

  logic [STAT_W-1:0] next_word;

  always_comb begin
    unique case (info_sel)
      INFO_APP1:
        next_word = {state, c_wden(ctrl), ctrl[TMO_MSB:TMO_LSB],
          WD_TAIL}; // RQ14
      INFO_APP2: next_word = addr_word(state, ctrl); // RQ15
      default: next_word = addr_word(state, ctrl); // RQ13
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      word <= '0;
    end else begin
      word <= next_word; // RQ12
    end
  end

endmodule

// ==== hdl/rsu_ctrl_status.sv ====
`timescale 1ns/1ns
// Contract
// RQ1: Serial scheme: control address clears to zero at power-up.
// RQ2: Parallel scheme: control address presets to the factory location.
// RQ3: Parallel scheme factory address can be replaced via scan instruction.
// RQ4: Control register writable only while factory image runs.
// RQ5: Control layout: reserved, early check, osc, watchdog, reserved, addr.
// RQ6: Watchdog count is timeout field with fixed 17-bit tail.
// RQ7: Boot address is address field with two zero low bits.
// RQ8: Early check rejects bad or early-done image, reloads factory.
// RQ9: Oscillator bit selects internal oscillator for startup clock.
// RQ10: Factory logic should set early check and oscillator bits.
// RQ11: Status records which condition triggered reconfiguration.
// RQ12: Current-state status is presented as a 32-bit word.
// RQ13: Factory info: state, zero padding, current boot address.
// RQ14: App info 1: state, watchdog enable, 29-bit timeout.
// RQ15: App info 2: state, zero padding, current boot address.
// RQ16: Control and status run on the startup clock domain.
// RQ17: Reconfiguration start copies update register into control.
// RQ18: Reserved control bits fixed: high reads one, low reads zero.
module rsu_ctrl_status (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Configuration scheme strap, high for parallel active
  input wire logic parallel_active_scheme,
  // Factory boot address load from the boundary-scan instruction
  input wire logic factory_boot_addr_instr,
  input wire logic [rsu_pkg::BOOT_W-1:0] factory_boot_addr_value,
  // Direct write from the factory image
  input wire logic ctrl_wr,
  input wire logic [rsu_pkg::CTRL_W-1:0] ctrl_wdata,
  // Update register contents and logic array trigger
  input wire logic [rsu_pkg::CTRL_W-1:0] update_data,
  input wire logic core_trigger,
  // Error events
  input wire logic crc_error,
  input wire logic status_error_pin,
  input wire logic config_reset,
  input wire logic watchdog_timeout,
  // Early done check of a freshly loaded application
  input wire logic image_check,
  input wire logic image_valid,
  input wire logic config_done_pin,
  // Status word select
  input wire logic [1:0] info_sel,
  // Control outputs
  output logic [rsu_pkg::CTRL_W-1:0] boot_control,
  output logic [rsu_pkg::BOOT_W-1:0] boot_address,
  output logic [rsu_pkg::WD_W-1:0] watchdog_count,
  output logic watchdog_enable_bit,
  output logic early_done_check,
  output logic osc_internal_sel,
  output logic early_check_fail,
  output rsu_pkg::rsu_master_e master_state,
  // Status outputs
  output logic [rsu_pkg::CAUSE_W-1:0] reconfig_cause_status,
  output logic [rsu_pkg::STAT_W-1:0] status_word
);
  import rsu_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Forces the reserved bits so no writer can disturb them.
  function automatic logic [CTRL_W-1:0] fix_rsv(
    input logic [CTRL_W-1:0] c
  );
    logic [CTRL_W-1:0] r;
    r = c;
    r[RSV_HIGH_POS] = RSV_HIGH_VAL; // RQ18
    r[RSV_LOW_POS] = RSV_LOW_VAL; // RQ18
    fix_rsv = r;
  endfunction

  // Control image that points at the factory image, all other fields clear.
  function automatic logic [CTRL_W-1:0] factory_ctrl(
    input logic [BOOT_W-1:0] addr
  );
    logic [CTRL_W-1:0] r;
    r = CTRL_RESET;
    r[ADDR_MSB:ADDR_LSB] = addr[BOOT_W-1:BOOT_W-ADDR_W];
    factory_ctrl = fix_rsv(r);
  endfunction

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic preset_done;
  logic [BOOT_W-1:0] factory_addr;
  logic [BOOT_W-1:0] default_addr;
  logic any_error;
  logic [CAUSE_W-1:0] cause_events;

  // The strap is only looked at after reset release, never inside it.
  assign default_addr = parallel_active_scheme ? factory_addr
                                               : SERIAL_FACTORY_ADDR;

  // Early check failure behaves as a load error.
  always_comb begin
    early_check_fail = 1'b0;
    if (master_state == RSU_APPLICATION && image_check &&
        boot_control[EARLY_POS]) begin
      early_check_fail = !image_valid || config_done_pin; // RQ8
    end
  end

  assign any_error = crc_error || status_error_pin || config_reset ||
                     watchdog_timeout || early_check_fail;

  // ----------------------------------------------------------------
  // Factory boot address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      factory_addr <= PARALLEL_FACTORY_ADDR; // RQ2
    end else if (factory_boot_addr_instr && parallel_active_scheme) begin
      factory_addr <= factory_boot_addr_value; // RQ3
    end
  end

  // ----------------------------------------------------------------
  // Master state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      master_state <= RSU_FACTORY;
    end else begin
      unique case (master_state)
        RSU_FACTORY: begin
          if (!any_error && core_trigger) begin
            master_state <= RSU_APPLICATION;
          end
        end
        RSU_APPLICATION: begin
          // Any trigger leaves the application; the factory image decides.
          if (any_error || core_trigger) begin
            master_state <= RSU_FACTORY;
          end
        end
        default: master_state <= RSU_FACTORY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      preset_done <= 1'b0;
      boot_control <= CTRL_RESET;
    end else if (!preset_done) begin
      preset_done <= 1'b1;
      boot_control <= factory_ctrl(default_addr); // RQ1 RQ2
    end else if (any_error) begin
      // Errors return to the factory image whatever was pending.
      boot_control <= factory_ctrl(default_addr);
    end else if (core_trigger) begin
      if (master_state == RSU_FACTORY) begin
        boot_control <= fix_rsv(update_data); // RQ17
      end else begin
        boot_control <= factory_ctrl(default_addr);
      end
    end else if (ctrl_wr && master_state == RSU_FACTORY) begin
      boot_control <= fix_rsv(ctrl_wdata); // RQ4 RQ5
    end
  end

  // ----------------------------------------------------------------
  // Derived control outputs
  // ----------------------------------------------------------------
  assign boot_address = {boot_control[ADDR_MSB:ADDR_LSB], BOOT_TAIL}; // RQ7
  assign watchdog_count = {boot_control[TMO_MSB:TMO_LSB], WD_TAIL}; // RQ6
  assign watchdog_enable_bit = boot_control[WDEN_POS];
  assign early_done_check = boot_control[EARLY_POS];
  assign osc_internal_sel = boot_control[OSC_POS]; // RQ9

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_comb begin
    cause_events = '0;
    cause_events[CAUSE_CFG_RESET] = config_reset;
    cause_events[CAUSE_CRC] = crc_error || early_check_fail;
    cause_events[CAUSE_STATUS_PIN] = status_error_pin;
    cause_events[CAUSE_WATCHDOG] = watchdog_timeout;
    cause_events[CAUSE_CORE] = core_trigger;
  end

  // Single clock for control and status: the startup clock domain.
  rsu_cause_rec u_cause ( // RQ16
    .clk_sys(clk_sys),
    .rstn(rstn),
    .events(cause_events),
    .cause(reconfig_cause_status)
  ); // RQ11

  rsu_status_word u_word (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .state(master_state),
    .ctrl(boot_control),
    .info_sel(info_sel),
    .word(status_word)
  );

endmodule

// ==== test/rsu_ctrl_status_checker.sv ====
`timescale 1ns/1ns
module rsu_ctrl_status_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Requests and events
  input wire logic ctrl_wr,
  input wire logic core_trigger,
  input wire logic crc_error,
  input wire logic status_error_pin,
  input wire logic config_reset,
  input wire logic watchdog_timeout,
  input wire logic factory_boot_addr_instr,
  input wire logic image_check,
  input wire logic image_valid,
  input wire logic config_done_pin,
  input wire logic [1:0] info_sel,
  input wire logic [38:0] ctrl_wdata,
  input wire logic [38:0] update_data,
  // Results
  input wire logic [38:0] boot_control,
  input wire logic [23:0] boot_address,
  input wire logic [28:0] watchdog_count,
  input wire logic watchdog_enable_bit,
  input wire logic early_done_check,
  input wire logic osc_internal_sel,
  input wire logic early_check_fail,
  input wire rsu_pkg::rsu_master_e master_state,
  input wire logic [4:0] reconfig_cause_status,
  input wire logic [31:0] status_word
);
  import rsu_pkg::*;
  logic up;
  logic [31:0] exp_word;
  wire errs = crc_error | status_error_pin | config_reset | watchdog_timeout
    | image_check | factory_boot_addr_instr;
  // The first edge after release loads the preset, so requests skip it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      up <= 1'b0;
    end else begin
      up <= 1'b1;
    end
  end
  always_comb begin
    if (info_sel == INFO_APP1) begin
      exp_word = {master_state, boot_control[35], boot_control[11:0], WD_TAIL};
    end else begin
      exp_word = {master_state, 6'h0, boot_control[33:12], BOOT_TAIL};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_fact_wr;
    up && ctrl_wr && !errs && !core_trigger && master_state == RSU_FACTORY;
  endsequence
  sequence s_app_wr;
    ctrl_wr && !errs && !core_trigger && master_state == RSU_APPLICATION;
  endsequence
  sequence s_core;
    up && core_trigger && !errs && master_state == RSU_FACTORY;
  endsequence
  sequence s_early_bad;
    master_state == RSU_APPLICATION && image_check && early_done_check &&
      (!image_valid || config_done_pin);
  endsequence
  a_early_fail: assert property (s_early_bad |-> early_check_fail)
    else $error("early check failure not flagged");
  a_early_load: assert property (s_early_bad && !config_reset |=>
    master_state == RSU_FACTORY && reconfig_cause_status == 5'h08)
    else $error("early check failure did not reload factory");
  a_early_pass: assert property (image_check && image_valid &&
    !config_done_pin |-> !early_check_fail)
    else $error("valid image flagged as early failure");
  a_wr_factory: assert property (s_fact_wr |=> boot_control ==
    {1'b1, $past(ctrl_wdata[37:35]), 1'b0, $past(ctrl_wdata[33:0])})
    else $error("factory write not taken");
  a_wr_refused: assert property (s_app_wr |=> $stable(boot_control))
    else $error("application write changed control");
  a_core_load: assert property (s_core |=>
    boot_control[37:35] == $past(update_data[37:35]) &&
    boot_control[33:0] == $past(update_data[33:0]) &&
    master_state == RSU_APPLICATION && reconfig_cause_status == 5'h01)
    else $error("core trigger did not load update");
  a_cfg_cause: assert property (up && config_reset |=>
    reconfig_cause_status == 5'h10 && master_state == RSU_FACTORY)
    else $error("config reset cause wrong");
  a_crc_cause: assert property (up && crc_error && !config_reset |=>
    reconfig_cause_status == 5'h08 && master_state == RSU_FACTORY)
    else $error("checksum cause wrong");
  a_addr_map: assert property (
    boot_address == {boot_control[33:12], BOOT_TAIL})
    else $error("boot address mapping wrong");
  a_wd_map: assert property (watchdog_count == {boot_control[11:0],
    WD_TAIL} && watchdog_enable_bit == boot_control[35] &&
    early_done_check == boot_control[37] && osc_internal_sel ==
    boot_control[36]) else $error("control field mapping wrong");
  a_rsv_fixed: assert property (boot_control[38] && !boot_control[34])
    else $error("reserved bits moved");
  a_word_map: assert property (up |=> status_word == $past(exp_word))
    else $error("status word wrong");
endmodule
bind rsu_ctrl_status rsu_ctrl_status_checker u_chk (.clk_sys, .rstn,
  .ctrl_wr, .core_trigger, .crc_error, .status_error_pin, .config_reset,
  .watchdog_timeout, .factory_boot_addr_instr, .image_check, .info_sel,
  .image_valid, .config_done_pin, .early_check_fail,
  .ctrl_wdata, .update_data, .boot_control, .boot_address, .watchdog_count,
  .watchdog_enable_bit, .early_done_check, .osc_internal_sel, .master_state,
  .reconfig_cause_status, .status_word);

// ==== test/rsu_soft_logic.sv ====
`timescale 1ns/1ns
module rsu_soft_logic (
  // Clock
  input wire logic clk_sys,
  // Requests to the control logic
  output logic ctrl_wr,
  output logic core_trigger,
  output logic [38:0] ctrl_wdata,
  output logic [38:0] update_data
);
  initial begin
    ctrl_wr = 1'b0;
    core_trigger = 1'b0;
    ctrl_wdata = '0;
    update_data = '0;
  end
  // Called at a falling edge; the request stands for one rising edge.
  task automatic send(input logic trig, input logic [38:0] d);
    if (trig) begin
      update_data = d | 39'h3000000000;
      core_trigger = 1'b1;
    end else begin
      ctrl_wdata = d;
      ctrl_wr = 1'b1;
    end
    @(negedge clk_sys);
    core_trigger = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = ~d;
  endtask
endmodule

// ==== test/test_remote_upgrade_ctrl_status_regs.sv ====
`timescale 1ns/1ns
module test_remote_upgrade_ctrl_status_regs;
  import rsu_pkg::*;
  typedef struct {logic [38:0] bc; logic [1:0] st; logic [4:0] ca;
    logic [1:0] sel;} rsu_note_s;
  logic clk_sys, rstn, parallel_active_scheme, factory_boot_addr_instr;
  logic crc_error, status_error_pin, config_reset, watchdog_timeout;
  logic image_check, image_valid, config_done_pin, ctrl_wr, core_trigger;
  logic watchdog_enable_bit, early_done_check, osc_internal_sel;
  logic early_check_fail;
  logic [1:0] info_sel, exp_st;
  logic [4:0] reconfig_cause_status, exp_ca;
  logic [23:0] factory_boot_addr_value, boot_address;
  logic [28:0] watchdog_count;
  logic [31:0] status_word;
  logic [38:0] ctrl_wdata, update_data, boot_control, exp_bc, dflt_bc;
  rsu_master_e master_state;
  int num_errors, checks_done, seed;
  rsu_note_s notes[$];
  rsu_ctrl_status u_dut (.clk_sys, .rstn, .parallel_active_scheme,
    .factory_boot_addr_instr, .factory_boot_addr_value, .ctrl_wr,
    .ctrl_wdata, .update_data, .core_trigger, .crc_error, .status_error_pin,
    .config_reset, .watchdog_timeout, .image_check, .image_valid,
    .config_done_pin, .info_sel, .boot_control, .boot_address,
    .watchdog_count, .watchdog_enable_bit, .early_done_check,
    .osc_internal_sel, .early_check_fail, .master_state,
    .reconfig_cause_status, .status_word);
  rsu_soft_logic u_soft (.clk_sys, .ctrl_wr, .core_trigger, .ctrl_wdata,
    .update_data);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  task automatic fail(input string m);
    num_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_ctrl(input rsu_note_s n);
    checks_done++;
    if (boot_control !== n.bc || master_state !== n.st ||
        reconfig_cause_status !== n.ca) fail("control or cause mismatch");
  endtask
  task automatic cmp_word(input logic [31:0] e);
    checks_done++;
    if (status_word !== e) fail("status word mismatch");
  endtask
  function automatic logic [31:0] exp_word(input rsu_note_s n);
    if (n.sel == 2'h1) return {n.st, n.bc[35], n.bc[11:0], 17'h00008};
    return {n.st, 6'h0, n.bc[33:12], 2'h0};
  endfunction
  initial forever begin
    rsu_note_s n;
    wait (notes.size() != 0);
    n = notes.pop_front();
    cmp_ctrl(n);
    @(negedge clk_sys);
    cmp_word(exp_word(n));
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  task automatic do_reset(input logic par);
    repeat (2) @(negedge clk_sys);
    rstn = 1'b0;
    parallel_active_scheme = par;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    exp_bc = dflt_bc;
    exp_st = RSU_FACTORY;
    exp_ca = 5'h0;
    @(negedge clk_sys);
    notes.push_back('{exp_bc, exp_st, exp_ca, info_sel});
  endtask
  // Kind 0 writes control, 1 triggers a reload, 2 raises error events.
  task automatic op(input int kind, input logic [38:0] d,
    input logic [4:0] ev);
    @(negedge clk_sys);
    info_sel = 2'($random(seed));
    {config_reset, crc_error, status_error_pin, watchdog_timeout,
      image_check} = ev;
    config_done_pin = 1'($random(seed));
    image_valid = 1'($random(seed));
    if (kind < 2) u_soft.send(kind[0], d);
    else @(negedge clk_sys);
    {config_reset, crc_error, status_error_pin, watchdog_timeout,
      image_check} = 5'h0;
    if (kind == 0 && exp_st == RSU_FACTORY) exp_bc = {1'b1, d[37:35], 1'b0,
      d[33:0]};
    if (kind == 1) begin
      // A trigger inside an application sends the device back home.
      exp_bc = (exp_st == RSU_FACTORY) ?
        {1'b1, d[37:35] | 3'b110, 1'b0, d[33:0]} : dflt_bc;
      exp_st = (exp_st == RSU_FACTORY) ? RSU_APPLICATION : RSU_FACTORY;
      exp_ca = 5'h01;
    end
    // A lone image check only acts on a bad image in an application.
    if (kind == 2 && (ev != 5'h01 || (exp_st == RSU_APPLICATION &&
        !(image_valid && !config_done_pin)))) begin
      exp_bc = dflt_bc;
      exp_st = RSU_FACTORY;
      exp_ca = ev[4] ? 5'h10 : (ev[3] | ev[0]) ? 5'h08 : ev[2] ? 5'h04 : 5'h02;
    end
    notes.push_back('{exp_bc, exp_st, exp_ca, info_sel});
  endtask
  initial begin
    logic [38:0] d;
    logic [4:0] evs [6];
    evs = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h18};
    seed = 32'h9682;
    {rstn, parallel_active_scheme, factory_boot_addr_instr, crc_error} = 4'h0;
    {status_error_pin, config_reset, watchdog_timeout, image_check} = 4'h0;
    {image_valid, config_done_pin} = 2'h0;
    info_sel = 2'h0;
    factory_boot_addr_value = 24'h0;
    dflt_bc = 39'h4000000000;
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      d = 39'({$random(seed), $random(seed)});
      op(0, d, 5'h0);
      op(1, d, 5'h0);
      op(0, ~d, 5'h0);
      op(2, d, evs[i]);
    end
    dflt_bc = 39'h4004000000;
    do_reset(1'b1);
    @(negedge clk_sys);
    factory_boot_addr_value = 24'($random(seed));
    factory_boot_addr_instr = 1'b1;
    @(negedge clk_sys);
    factory_boot_addr_instr = 1'b0;
    dflt_bc = {1'b1, 4'h0, factory_boot_addr_value[23:2], 12'h0};
    op(2, d, 5'h08);
    repeat (3) @(negedge clk_sys);
    if (notes.size() != 0) fail("results never checked");
    test_done();
  end
  initial begin
    #(2000 * 50);
    fail("timeout");
    test_done();
  end
endmodule
